// file: bench/rsm_regs_asserts.sv
// checker: port timing properties of the reference monitor register bank
`timescale 1ns/10ps
`default_nettype none
module rsm_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [11:0] referenceFreqCodeIn,
    input wire logic [8:0] frameInputFreqCodeIn,
    input wire logic [2:0] referenceFailed,
    input wire logic [2:0] referenceFreqKnown,
    input wire logic [2:0] frameInputFreqKnown,
    input wire logic [11:0] referenceMonitorMask,
    input wire logic [2:0] first_reference_range_limit,
    input wire logic [2:0] second_reference_range_limit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic wrTake;
    logic rdTake;
    logic [7:0] lastW;
    assign wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    assign rdTake = s_axi_arvalid && s_axi_arready;
    // last written byte, target of the output copies
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lastW <= 8'h00;
        end else if (wrTake) begin
            lastW <= s_axi_wdata[7:0];
        end
    end
    property p_ref_known;
        1'b1 |=> referenceFreqKnown[0] == ($past(referenceFreqCodeIn[3:0]) <= 4'hA)
            && referenceFreqKnown[1] == ($past(referenceFreqCodeIn[7:4]) <= 4'hA)
            && referenceFreqKnown[2] == ($past(referenceFreqCodeIn[11:8]) <= 4'hA);
    endproperty
    a_ref_known: assert property (p_ref_known) else $error("reference known flag wrong");
    property p_sync_known;
        1'b1 |=> frameInputFreqKnown[0] == ($past(frameInputFreqCodeIn[2:0]) != 3'h6)
            && frameInputFreqKnown[1] == ($past(frameInputFreqCodeIn[5:3]) != 3'h6)
            && frameInputFreqKnown[2] == ($past(frameInputFreqCodeIn[8:6]) != 3'h6);
    endproperty
    a_sync_known: assert property (p_sync_known) else $error("frame input known flag wrong");
    property p_b_hold;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready
            ##1 ($past(s_axi_bready) || (s_axi_bvalid && $stable(s_axi_bresp)));
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid |-> !s_axi_arready
            ##1 ($past(s_axi_rready) || (s_axi_rvalid && $stable(s_axi_rdata)));
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_upper_zero;
        rdTake && (s_axi_araddr == 8'h44 || s_axi_araddr == 8'h54) |=> s_axi_rvalid && s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("reserved nibble not zero");
    property p_range_rsvd;
        rdTake && s_axi_araddr == 8'h58 |=> !s_axi_rdata[3] && !s_axi_rdata[7];
    endproperty
    a_range_rsvd: assert property (p_range_rsvd) else $error("range reserved bits set");
    property p_range_out;
        wrTake && s_axi_awaddr == 8'h58 |-> ##[1:4] first_reference_range_limit == lastW[2:0]
            && second_reference_range_limit == lastW[6:4];
    endproperty
    a_range_out: assert property (p_range_out) else $error("range limit outputs not updated");
    property p_mask01_out;
        wrTake && s_axi_awaddr == 8'h30 |-> ##[1:4] referenceMonitorMask[7:0] == lastW;
    endproperty
    a_mask01_out: assert property (p_mask01_out) else $error("ref0 ref1 mask output wrong");
    property p_mask2_out;
        wrTake && s_axi_awaddr == 8'h34 |-> ##[1:4] referenceMonitorMask[11:8] == lastW[3:0];
    endproperty
    a_mask2_out: assert property (p_mask2_out) else $error("ref2 mask output wrong");
    c_write: cover property (wrTake);
    c_read: cover property (rdTake);
    c_failed: cover property ($rose(referenceFailed[0]));
endmodule // rsm_asserts
bind ref_sync_monitor_regs rsm_asserts chk_u (.*);
`default_nettype wire

// file: bench/tb_ref_sync_monitor_regs.sv
// testbench: register bank checks through the AXI4-Lite slave port
`timescale 1ns/10ps
`default_nettype none
module tb_ref_sync_monitor_regs;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, d;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, frameInputFailedIn = 3'h0, f;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [11:0] monitorFailEvent = 12'h000, referenceFreqCodeIn = 12'hFFF, referenceMonitorMask;
    logic [8:0] frameInputFreqCodeIn = 9'h1B6;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] referenceFailed, referenceFreqKnown, frameInputFreqKnown;
    logic [2:0] first_reference_range_limit, second_reference_range_limit;
    logic [17:0] rq[$];
    logic [1:0] bq[$];
    logic [17:0] rx;
    int err_total = 0, n_compared = 0, cyc = 0;
    ref_sync_monitor_regs dut_u (.*);
    always #5 clk = ~clk;
    // ****************************************
    // compare and report
    // ****************************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // response watcher, oldest note first
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            rx = rq.pop_front();
            chk({s_axi_rresp, s_axi_rdata & {24'hFFFFFF, rx[17:10]}}, {rx[9:8], 24'h0, rx[7:0] & rx[17:10]});
        end
        if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop;
        end
    end
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e, input logic [3:0] s = 4'hF);
        bq.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($urandom()), v};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e = 2'h0, input logic [7:0] m = 8'hFF);
        rq.push_back({m, e, v});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input logic [11:0] v);
        monitorFailEvent <= v;
        @(posedge clk);
        monitorFailEvent <= 12'h000;
        repeat (3) @(posedge clk);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h9B2F));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(referenceMonitorMask, 12'hFFF);
        chk({first_reference_range_limit, second_reference_range_limit}, 6'h1B);
        rd(8'h30, 8'hFF);
        rd(8'h34, 8'hFF);
        rd(8'h58, 8'h33);
        rd(8'h40, 8'hFF);
        rd(8'h44, 8'h0F);
        rd(8'h50, 8'h66);
        rd(8'h54, 8'h06);
        rd(8'h14, 8'h00);
        rd(8'h18, 8'h00);
        rd(8'h08, 8'h00, 2'h2, 8'h00);
        wr(8'h08, 8'h5A, 2'h2);
        wr(8'h40, 8'h00, 2'h0);
        wr(8'h58, 8'h00, 2'h0, 4'h0);
        rd(8'h40, 8'hFF);
        rd(8'h58, 8'h33);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom());
            wr(8'h30, d, 2'h0);
            wr(8'h34, ~d, 2'h0);
            wr(8'h58, d, 2'h0);
            rd(8'h30, d);
            rd(8'h34, ~d);
            rd(8'h58, d & 8'h77);
            chk({referenceMonitorMask, first_reference_range_limit, second_reference_range_limit}, {~d[3:0], d, d[2:0], d[6:4]});
        end
        for (int c = 0; c < 16; c++) begin
            referenceFreqCodeIn <= {4'(c), 4'(15 - c), 4'(c)};
            repeat (2) @(posedge clk);
            chk(referenceFreqKnown, {c <= 10, 15 - c <= 10, c <= 10});
            rd(8'h40, {4'(15 - c), 4'(c)});
            rd(8'h44, {4'h0, 4'(c)});
        end
        for (int c = 0; c < 8; c++) begin
            f = 3'($urandom());
            frameInputFreqCodeIn <= {3'(c), 3'(7 - c), 3'(c)};
            frameInputFailedIn <= f;
            repeat (2) @(posedge clk);
            chk(frameInputFreqKnown, {c != 6, 7 - c != 6, c != 6});
            rd(8'h50, {f[1], 3'(7 - c), f[0], 3'(c)});
            rd(8'h54, {4'h0, f[2], 3'(c)});
        end
        for (int m = 0; m < 4; m++) begin
            wr(8'h30, 8'(1 << m), 2'h0);
            pulse(12'(1 << ((m + 1) % 4)));
            chk(referenceFailed[0], 1'b0);
            rd(8'h14, 8'(1 << ((m + 1) % 4)));
            pulse(12'(1 << m));
            chk(referenceFailed[0], 1'b1);
            rd(8'h14, 8'(1 << m));
        end
        wr(8'h30, 8'hF0, 2'h0);
        wr(8'h34, 8'h0F, 2'h0);
        pulse(12'h821);
        chk(referenceFailed, 3'h6);
        rd(8'h14, 8'h21);
        rd(8'h14, 8'h00);
        rd(8'h18, 8'h08);
        // event lands on the read-clear edge: set must win
        pulse(12'h002);
        fork
            pulse(12'h002);
            rd(8'h14, 8'h02);
        join
        rd(8'h14, 8'h02);
        rd(8'h14, 8'h00);
        report_and_stop;
    end
endmodule // tb_ref_sync_monitor_regs
`default_nettype wire

// file: src/ref_sync_monitor_regs.sv
// top: AXI4-Lite register bank for reference and sync monitor supervision
// Operation
// - each reference has four mask bits: single-cycle, coarse, guard soak, precise; zero masks
// - third reference mask in bits 3:0 of second mask register, resets all unmasked
// - reference frequency is a 4-bit code, 0 to A known, F not detected
// - ref0 code bits 3:0, ref1 bits 7:4; ref2 in next register; read-only
// - sync frequency is a 3-bit code; code 6 means not yet detected
// - read-only sync fail flags at bits 3 and 7, sync2 in next register
// - 3-bit out-of-range limit, ref0 bits 2:0, ref1 bits 6:4; none for ref2
// - sticky read-only failure flags per reference per monitor, 1 means failed
`timescale 1ns/10ps
`default_nettype none
module ref_sync_monitor_regs (
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [rsm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rsm_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rsm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [rsm_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // monitor side, same clock
    input wire logic [11:0] monitorFailEvent,
    input wire logic [11:0] referenceFreqCodeIn,
    input wire logic [8:0] frameInputFreqCodeIn,
    input wire logic [2:0] frameInputFailedIn,
    // supervision outputs
    output logic [2:0] referenceFailed,
    output logic [2:0] referenceFreqKnown,
    output logic [2:0] frameInputFreqKnown,
    output logic [11:0] referenceMonitorMask,
    output logic [2:0] first_reference_range_limit,
    output logic [2:0] second_reference_range_limit
);

    // ****************************************
    // helpers
    // ****************************************
    rsm_core_if coreLink ();

    rsm_sticky_bits uSticky (
        .clk(clk),
        .rst(rst),
        .link(coreLink.sticky)
    );

    rsm_detect_latch uDetect (
        .clk(clk),
        .rst(rst),
        .link(coreLink.detect)
    );

    assign coreLink.stickySet = monitorFailEvent;
    assign coreLink.refCodeIn = referenceFreqCodeIn;
    assign coreLink.syncCodeIn = frameInputFreqCodeIn;
    assign coreLink.syncFailIn = frameInputFailedIn;

    // ****************************************
    // control registers
    // ****************************************
    logic [7:0] ref01MonitorMask;
    logic [7:0] ref2MonitorMask;
    logic [7:0] rangeLimitSelectLow;

    // ****************************************
    // write channel
    // ****************************************
    logic awHeld;
    logic wHeld;
    logic [5:0] wrIndex;
    logic [7:0] wrByte;
    logic wrByteEn;
    logic wrDo;

    assign wrDo = awHeld && wHeld && !s_axi_bvalid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHeld <= 1'b0;
            wrIndex <= 6'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            wrIndex <= s_axi_awaddr[7:2];
        end else if (wrDo) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wHeld <= 1'b0;
            wrByte <= 8'h00;
            wrByteEn <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wrByte <= s_axi_wdata[7:0];
            wrByteEn <= s_axi_wstrb[0];
        end else if (wrDo) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rsm_pkg::RESP_OKAY;
        end else if (wrDo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= rsm_pkg::regMapped(wrIndex) ? rsm_pkg::RESP_OKAY : rsm_pkg::RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // mask registers, zero in a bit masks that indicator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref01MonitorMask <= rsm_pkg::RST_REF01_MASK;
            ref2MonitorMask <= rsm_pkg::RST_REF2_MASK;
        end else if (wrDo && wrByteEn) begin
            if (wrIndex == rsm_pkg::IDX_REF01_MASK) begin
                ref01MonitorMask <= wrByte;
            end
            if (wrIndex == rsm_pkg::IDX_REF2_MASK) begin
                ref2MonitorMask <= wrByte;
            end
        end
    end

    // range selection, reserved bits 3 and 7 stay zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rangeLimitSelectLow <= rsm_pkg::RST_RANGE_LOW;
        end else if (wrDo && wrByteEn && wrIndex == rsm_pkg::IDX_RANGE_LOW) begin
            rangeLimitSelectLow <= wrByte & rsm_pkg::RANGE_LOW_WRITABLE;
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    logic [5:0] rdIndex;
    logic [7:0] rdByte;
    logic rdTake;

    assign rdTake = s_axi_arvalid && s_axi_arready;
    assign rdIndex = s_axi_araddr[7:2];

    always_comb begin
        rdByte = 8'h00;
        case (rdIndex)
            rsm_pkg::IDX_MON_STATUS_LOW: rdByte = coreLink.stickyStatus[7:0];
            rsm_pkg::IDX_MON_STATUS_HIGH: rdByte = {4'h0, coreLink.stickyStatus[11:8]};
            rsm_pkg::IDX_REF01_MASK: rdByte = ref01MonitorMask;
            rsm_pkg::IDX_REF2_MASK: rdByte = ref2MonitorMask;
            rsm_pkg::IDX_REF_FREQ_LOW: rdByte = coreLink.refCode[7:0];
            rsm_pkg::IDX_REF_FREQ_HIGH: rdByte = {4'h0, coreLink.refCode[11:8]};
            rsm_pkg::IDX_SYNC_LOW: rdByte = {coreLink.syncFail[1], coreLink.syncCode[5:3],
                                             coreLink.syncFail[0], coreLink.syncCode[2:0]};
            rsm_pkg::IDX_SYNC_HIGH: rdByte = {4'h0, coreLink.syncFail[2], coreLink.syncCode[8:6]};
            rsm_pkg::IDX_RANGE_LOW: rdByte = rangeLimitSelectLow;
            default: rdByte = 8'h00;
        endcase
    end

    // reading a status register clears what it returned
    always_comb begin
        coreLink.stickyClear = 12'h000;
        if (rdTake && rdIndex == rsm_pkg::IDX_MON_STATUS_LOW) begin
            coreLink.stickyClear[7:0] = coreLink.stickyStatus[7:0];
        end
        if (rdTake && rdIndex == rsm_pkg::IDX_MON_STATUS_HIGH) begin
            coreLink.stickyClear[11:8] = coreLink.stickyStatus[11:8];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rdTake;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= rsm_pkg::RESP_OKAY;
        end else if (rdTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rdByte};
            s_axi_rresp <= rsm_pkg::regMapped(rdIndex) ? rsm_pkg::RESP_OKAY : rsm_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // supervision outputs
    // ****************************************
    logic [11:0] maskAll;
    assign maskAll = {ref2MonitorMask[3:0], ref01MonitorMask};

    genvar r;
    generate
        for (r = 0; r < rsm_pkg::NUM_REF; r++) begin : gRefFail
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    referenceFailed[r] <= 1'b0;
                end else begin
                    referenceFailed[r] <= |(coreLink.stickyStatus[4*r +: 4] & maskAll[4*r +: 4]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            referenceMonitorMask <= {rsm_pkg::RST_REF2_MASK[3:0], rsm_pkg::RST_REF01_MASK};
            first_reference_range_limit <= rsm_pkg::RST_RANGE_LOW[2:0];
            second_reference_range_limit <= rsm_pkg::RST_RANGE_LOW[6:4];
        end else begin
            referenceMonitorMask <= maskAll;
            first_reference_range_limit <= rangeLimitSelectLow[2:0];
            second_reference_range_limit <= rangeLimitSelectLow[6:4];
        end
    end

    assign referenceFreqKnown = coreLink.refKnown;
    assign frameInputFreqKnown = coreLink.syncKnown;

    logic unusedProt;
    assign unusedProt = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1],
                          s_axi_awaddr[1:0], s_axi_araddr[1:0]};

endmodule // ref_sync_monitor_regs
`default_nettype wire

// file: src/rsm_core_if.sv
// interface: links between the register bank and its sticky and detect helpers
`timescale 1ns/10ps
`default_nettype none
interface rsm_core_if;
    logic [11:0] stickySet;
    logic [11:0] stickyClear;
    logic [11:0] stickyStatus;
    logic [11:0] refCodeIn;
    logic [8:0] syncCodeIn;
    logic [2:0] syncFailIn;
    logic [11:0] refCode;
    logic [8:0] syncCode;
    logic [2:0] syncFail;
    logic [2:0] refKnown;
    logic [2:0] syncKnown;

    modport sticky (input stickySet, input stickyClear, output stickyStatus);
    modport detect (input refCodeIn, input syncCodeIn, input syncFailIn,
                    output refCode, output syncCode, output syncFail, output refKnown, output syncKnown);
    modport core (output stickySet, output stickyClear, input stickyStatus,
                  output refCodeIn, output syncCodeIn, output syncFailIn,
                  input refCode, input syncCode, input syncFail, input refKnown, input syncKnown);
endinterface
`default_nettype wire

// file: src/rsm_detect_latch.sv
// registers detected frequency codes and sync fail flags, flags known codes
`timescale 1ns/10ps
`default_nettype none
module rsm_detect_latch (
    input wire logic clk,
    input wire logic rst,
    rsm_core_if.detect link
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.refCode <= {3{rsm_pkg::REF_CODE_UNKNOWN}};
            link.syncCode <= {3{rsm_pkg::SYNC_CODE_UNKNOWN}};
            link.syncFail <= 3'h0;
        end else begin
            link.refCode <= link.refCodeIn;
            link.syncCode <= link.syncCodeIn;
            link.syncFail <= link.syncFailIn;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : gKnown
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    link.refKnown[i] <= 1'b0;
                    link.syncKnown[i] <= 1'b0;
                end else begin
                    link.refKnown[i] <= rsm_pkg::refCodeKnown(link.refCodeIn[4*i +: 4]);
                    link.syncKnown[i] <= rsm_pkg::syncCodeKnown(link.syncCodeIn[3*i +: 3]);
                end
            end
        end
    endgenerate
endmodule // rsm_detect_latch
`default_nettype wire

// file: src/rsm_pkg.sv
// package: register map, field layout and codes of the reference monitor register bank
package rsm_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NUM_REF = 3;
    localparam int NUM_SYNC = 3;
    localparam int NUM_MON = 4;

    // ****************************************
    // register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [5:0] IDX_MON_STATUS_LOW = 6'h05;
    localparam logic [5:0] IDX_MON_STATUS_HIGH = 6'h06;
    localparam logic [5:0] IDX_REF01_MASK = 6'h0C;
    localparam logic [5:0] IDX_REF2_MASK = 6'h0D;
    localparam logic [5:0] IDX_REF_FREQ_LOW = 6'h10;
    localparam logic [5:0] IDX_REF_FREQ_HIGH = 6'h11;
    localparam logic [5:0] IDX_SYNC_LOW = 6'h14;
    localparam logic [5:0] IDX_SYNC_HIGH = 6'h15;
    localparam logic [5:0] IDX_RANGE_LOW = 6'h16;

    // ****************************************
    // reset values and field layout
    // ****************************************
    localparam logic [7:0] RST_REF01_MASK = 8'hFF;
    localparam logic [7:0] RST_REF2_MASK = 8'hFF;
    localparam logic [7:0] RST_RANGE_LOW = 8'h33;
    localparam logic [7:0] RANGE_LOW_WRITABLE = 8'h77;
    localparam int MON_SINGLE_CYCLE = 0;
    localparam int MON_COARSE_FREQ = 1;
    localparam int MON_GUARD_SOAK = 2;
    localparam int MON_PRECISE_FREQ = 3;
    localparam logic [3:0] REF_CODE_MAX = 4'hA;
    localparam logic [3:0] REF_CODE_UNKNOWN = 4'hF;
    localparam logic [2:0] SYNC_CODE_UNKNOWN = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // code decoders
    // ****************************************
    function automatic logic refCodeKnown(input logic [3:0] code);
        refCodeKnown = (code <= REF_CODE_MAX);
    endfunction

    function automatic logic syncCodeKnown(input logic [2:0] code);
        syncCodeKnown = (code != SYNC_CODE_UNKNOWN);
    endfunction

    function automatic logic regMapped(input logic [5:0] idx);
        case (idx)
            IDX_MON_STATUS_LOW, IDX_MON_STATUS_HIGH, IDX_REF01_MASK, IDX_REF2_MASK,
            IDX_REF_FREQ_LOW, IDX_REF_FREQ_HIGH, IDX_SYNC_LOW, IDX_SYNC_HIGH,
            IDX_RANGE_LOW: regMapped = 1'b1;
            default: regMapped = 1'b0;
        endcase
    endfunction

endpackage

// file: src/rsm_sticky_bits.sv
// sticky monitor failure flags, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module rsm_sticky_bits (
    input wire logic clk,
    input wire logic rst,
    rsm_core_if.sticky link
);
    genvar i;
    generate
        for (i = 0; i < 12; i++) begin : gBit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    link.stickyStatus[i] <= 1'b0;
                end else if (link.stickySet[i]) begin
                    link.stickyStatus[i] <= 1'b1;
                end else if (link.stickyClear[i]) begin
                    link.stickyStatus[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // rsm_sticky_bits
`default_nettype wire
